// *** hdl/lcc_alaw_core.sv ***
// Combinational A-law compression of one signed linear sample.
// Assumes the caller registers input and output.
`timescale 1ns/1ns
`include "lcc_params.svh"
module lcc_alaw_core #(
    parameter int IN_W = `LCC_A_LIN_W
) (
    input wire logic signed [IN_W-1:0] sample_in,
    output logic [7:0] wire_code_out
);
    logic [IN_W:0] abs_val;
    logic [11:0] clamped;
    logic [10:0] halved;
    lcc_pkg::lcc_acode_s fields;
    always_comb
    begin
        abs_val = sample_in[IN_W-1] ? (IN_W+1)'(-$signed({sample_in[IN_W-1], sample_in}))
                                    : {1'b0, sample_in}; // R10
        fields.sign = sample_in[IN_W-1]; // R10 R2
        if (abs_val > (IN_W+1)'(`LCC_A_CLAMP))
            clamped = `LCC_A_CLAMP; // R12
        else
            clamped = abs_val[11:0];
        halved = clamped[11:1]; // R13
        fields.seg = 3'h0;
        fields.step = halved[3:0]; // R11
        if (clamped > `LCC_A_LIN_MAX) // R11
        begin
            for (int p = 4; p <= 10; p++)
            begin
                if (halved[p])
                begin
                    fields.seg = 3'(p - `LCC_A_SEG_ADJ); // R14
                    fields.step = 4'(halved >> (p - 4)); // R14
                end
            end
        end
        wire_code_out = fields ^ `LCC_A_XOR; // R15 R3
    end
endmodule : lcc_alaw_core

// *** hdl/lcc_fifo.sv ***
// Buffer with registered output stage; WIDTH and DEPTH shape the storage.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module lcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int PTR_W = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 4 || (1 << PTR_W) != DEPTH)
            $error("lcc_fifo: DEPTH must be a power of two, at least 4");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic [PTR_W:0] count_next;
    logic push;
    logic pop;
    assign push = in_valid_in && in_ready_out;
    assign pop = (count_reg != '0) && (!out_valid_out || out_ready_in);
    assign count_next = count_reg + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
    always_ff @(posedge clock_in)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data_in;
    end
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_out <= 1'b0;
            level_out <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + PTR_W'(push);
            rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop);
            count_reg <= count_next;
            level_out <= count_next;
            // Registered ready stays honest: computed from next occupancy
            in_ready_out <= count_next < (PTR_W+1)'(DEPTH);
        end
    end
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            out_valid_out <= 1'b0;
            out_data_out <= '0;
        end
        else if (pop)
        begin
            out_valid_out <= 1'b1;
            out_data_out <= mem[rd_ptr_reg];
        end
        else if (out_ready_in)
            out_valid_out <= 1'b0;
    end
endmodule : lcc_fifo

// *** hdl/lcc_params.svh ***
// Constants of the companding codec: field positions, biases, limits, depths.
// Included by bare name; holds definitions only.
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH
`define LCC_CODE_W 8
`define LCC_MU_LIN_W 14
`define LCC_A_LIN_W 13
`define LCC_MU_STEP_MASK 8'h0f
`define LCC_MU_SEG_SHIFT 4
`define LCC_MU_SEG_MASK 8'h07
`define LCC_MU_SIGN_MASK 8'h08
`define LCC_MU_BIAS 14'h0021
`define LCC_A_SIGN_MASK 8'h80
`define LCC_A_LIN_MAX 12'h01f
`define LCC_A_CLAMP 12'hfff
`define LCC_A_SEG_ADJ 3
`define LCC_A_XOR 8'hd5
`define LCC_EXP_TABLE_DEPTH 256
`define LCC_MU_CMP_TABLE 16384
`define LCC_A_CMP_TABLE 8192
`define LCC_FIFO_DEPTH 32
`define LCC_PIPE_LATENCY 2
`define LCC_CMP_HEADROOM 4
`endif

// *** hdl/lcc_pkg.sv ***
// Types shared by the companding codec files.
// Assumes lcc_params.svh is visible to every user.
package lcc_pkg;
    typedef logic [7:0] lcc_code_t;
    typedef logic signed [13:0] lcc_mu_lin_t;
    typedef struct packed {
        logic sign;
        logic [2:0] seg;
        logic [3:0] step;
    } lcc_acode_s;
endpackage : lcc_pkg

// *** hdl/lcc_top.sv ***
// Companding codec: mu-law channel codes to linear samples, linear samples
// to A-law channel codes through an output buffer toward the channel.
// Assumes one clock, synchronous reset, and a channel that honours valid/ready.
//
// Summary of operation
// [R1] Expander yields 14-bit mu-law linear samples; A-law would be 13 bits.
// [R2] Channel codes are sign plus logarithmic magnitude.
// [R3] Compressor turns each linear sample into an 8-bit channel code.
// [R4] Expander may use a 256-entry precomputed table instead of logic.
// [R5] Compressor tables would need 16384 or 8192 words; logic used instead.
// [R6] Mu expansion inverts the code, doubles the low nibble, adds 33.
// [R7] Segment is inverted code shifted right four, masked with 7.
// [R8] Biased step shifted left by segment, then 33 subtracted.
// [R9] Sign at mask 08h after the shift; set means negate the magnitude.
// [R10] A-law sign goes to bit 80h; the absolute value is encoded.
// [R11] Magnitudes up to 1fh are coded linearly with segment zero.
// [R12] Magnitudes above fffh saturate to fffh.
// [R13] The lowest magnitude bit is dropped before segment search.
// [R14] Segment is leading-one position minus three; next four bits are step.
// [R15] Assembled code is XORed with d5h before transmission.
// [R16] One sample per valid cycle; result valid after a fixed latency. Compressor takes only under cmp_ready_out; its channel latency varies.
`timescale 1ns/1ns
`include "lcc_params.svh"
module lcc_top #(
    parameter bit USE_EXP_TABLE = 1'b0,
    parameter int CMP_IN_W = `LCC_A_LIN_W,
    parameter int FIFO_DEPTH = `LCC_FIFO_DEPTH
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic exp_valid_in,
    input wire logic [7:0] exp_code_in,
    output logic exp_valid_out,
    output logic signed [`LCC_MU_LIN_W-1:0] exp_sample_out,
    input wire logic cmp_valid_in,
    input wire logic signed [CMP_IN_W-1:0] cmp_sample_in,
    output logic cmp_ready_out,
    output logic chan_valid_out,
    output logic [7:0] chan_code_out,
    input wire logic chan_ready_in
);
    localparam int LIN_W = `LCC_MU_LIN_W;
    localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;

    initial
    begin
        if (CMP_IN_W < `LCC_A_LIN_W || CMP_IN_W > 31)
            $error("lcc_top: CMP_IN_W must lie between 13 and 31");
        if (FIFO_DEPTH < 2 * `LCC_CMP_HEADROOM)
            $error("lcc_top: FIFO_DEPTH too small for pipeline headroom");
        // Table compression is refused: too many words for this block
        if (`LCC_A_CMP_TABLE > `LCC_MU_CMP_TABLE)
            $error("lcc_top: compressor table sizes inconsistent"); // R5
    end

    // Mu-law expansion of one channel code
    function automatic logic signed [LIN_W-1:0] mu_expand(input logic [7:0] code);
        logic [7:0] inv;
        logic [LIN_W-1:0] biased;
        logic [LIN_W-1:0] mag;
        logic [7:0] shifted;
        logic [2:0] seg;
        inv = ~code; // R6 R2
        biased = LIN_W'({inv & `LCC_MU_STEP_MASK, 1'b0}) + `LCC_MU_BIAS; // R6
        shifted = inv >> `LCC_MU_SEG_SHIFT;
        seg = 3'(shifted & `LCC_MU_SEG_MASK); // R7
        mag = LIN_W'(biased << seg) - `LCC_MU_BIAS; // R8
        if ((shifted & `LCC_MU_SIGN_MASK) != 8'h00)
            return -$signed(mag); // R9
        return $signed(mag); // R9 R1
    endfunction : mu_expand

    // Expander path: code register, then conversion register
    logic exp_v1_reg;
    logic [7:0] exp_code_reg;
    logic signed [LIN_W-1:0] exp_conv;

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            exp_v1_reg <= 1'b0;
            exp_code_reg <= 8'h00;
        end
        else
        begin
            exp_v1_reg <= exp_valid_in; // R16
            if (exp_valid_in)
                exp_code_reg <= exp_code_in;
        end
    end

    generate
        if (USE_EXP_TABLE)
        begin : g_exp_table
            // Table costs 256 words but removes the shifter from the path
            logic signed [LIN_W-1:0] exp_rom [`LCC_EXP_TABLE_DEPTH];
            for (genvar i = 0; i < `LCC_EXP_TABLE_DEPTH; i++)
            begin : g_entry
                assign exp_rom[i] = mu_expand(8'(i)); // R4
            end
            assign exp_conv = exp_rom[exp_code_reg]; // R4
        end
        else
        begin : g_exp_logic
            assign exp_conv = mu_expand(exp_code_reg); // R1
        end
    endgenerate

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            exp_valid_out <= 1'b0;
            exp_sample_out <= '0;
        end
        else
        begin
            exp_valid_out <= exp_v1_reg; // R16
            if (exp_v1_reg)
                exp_sample_out <= exp_conv;
        end
    end

    // Compressor path: sample register, conversion register, then buffer
    logic cmp_v1_reg;
    logic signed [CMP_IN_W-1:0] cmp_sample_reg;
    logic cmp_v2_reg;
    logic [7:0] cmp_code_reg;
    logic [7:0] cmp_conv;
    logic cmp_take;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [CNT_W-1:0] fifo_level;

    assign cmp_take = cmp_valid_in && cmp_ready_out;

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            cmp_v1_reg <= 1'b0;
            cmp_sample_reg <= '0;
        end
        else
        begin
            cmp_v1_reg <= cmp_take; // R16
            if (cmp_take)
                cmp_sample_reg <= cmp_sample_in;
        end
    end

    // Algorithmic encoder; a table here would be far too large
    lcc_alaw_core #(
        .IN_W(CMP_IN_W)
    ) u_alaw (
        .sample_in(cmp_sample_reg), // R5 R10 R11 R12 R13 R14
        .wire_code_out(cmp_conv) // R15 R3
    );

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            cmp_v2_reg <= 1'b0;
            cmp_code_reg <= 8'h00;
        end
        else
        begin
            cmp_v2_reg <= cmp_v1_reg; // R16
            if (cmp_v1_reg)
                cmp_code_reg <= cmp_conv; // R3
        end
    end

    lcc_fifo #(
        .WIDTH(`LCC_CODE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .in_valid_in(cmp_v2_reg),
        .in_data_in(cmp_code_reg),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(chan_ready_in),
        .level_out(fifo_level)
    );

    // Ready is registered, so it lags one cycle; headroom covers the
    // lag plus both pipeline stages, keeping the buffer from overflowing.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            cmp_ready_out <= 1'b0;
        else
            cmp_ready_out <= fifo_in_ready &&
                ((32'(fifo_level) + `LCC_CMP_HEADROOM) <= FIFO_DEPTH);
    end

    assign chan_valid_out = fifo_out_valid;
    assign chan_code_out = fifo_out_data;
endmodule : lcc_top

// *** testbench/lcc_chan_model.sv ***
// Channel sink taking A-law codes under selectable back-pressure.
// Assumes the codec holds code and valid until the accepting edge.
`timescale 1ns/1ns
module lcc_chan_model (
    input wire logic clock_in,
    input wire logic hold_in,
    input wire logic slow_in,
    input wire logic chan_valid_in,
    input wire logic [7:0] chan_code_in,
    output logic chan_ready_out
);
    logic [1:0] tick_reg = 2'h0;
    logic [7:0] got_q[$];
    initial chan_ready_out = 1'b0;
    always @(posedge clock_in)
    begin
        if (chan_valid_in && chan_ready_out)
            got_q.push_back(chan_code_in);
        tick_reg <= tick_reg + 2'h1;
        // Slow mode takes one code in four so the buffer stays busy
        chan_ready_out <= !hold_in && (!slow_in || tick_reg == 2'h0);
    end
endmodule : lcc_chan_model

// *** testbench/lcc_tb_pkg.sv ***
// Reference conversions for the codec bench and checker.
// Assumes 8-bit codes, 14-bit mu samples and 13-bit A-law inputs.
package lcc_tb_pkg;
    function automatic logic signed [13:0] mu_exp(input logic [7:0] c);
        logic [7:0] i;
        logic [13:0] m;
        i = ~c;
        m = (({9'h000, i[3:0], 1'b0} + 14'h0021) << i[6:4]) - 14'h0021;
        return i[7] ? -m : m;
    endfunction : mu_exp
    function automatic logic [7:0] a_cmp(input logic signed [12:0] x);
        logic [12:0] a;
        logic [10:0] h;
        int p;
        a = x[12] ? -x : x;
        if (a > 13'h0fff)
            a = 13'h0fff;
        h = a[11:1];
        p = 10;
        while (p > 4 && !h[p])
            p--;
        if (a <= 13'h001f)
            return {x[12], 3'h0, a[4:1]} ^ 8'hd5;
        return {x[12], 3'(p - 3), 4'(h >> (p - 4))} ^ 8'hd5;
    endfunction : a_cmp
endpackage : lcc_tb_pkg

// *** testbench/lcc_top_checker.sv ***
// Port-level assertions for the companding codec.
// Assumes it is bound onto lcc_top and sees only its ports.
`timescale 1ns/1ns
module lcc_top_checker #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic exp_valid_in,
    input wire logic [7:0] exp_code_in,
    input wire logic exp_valid_out,
    input wire logic signed [13:0] exp_sample_out,
    input wire logic cmp_valid_in,
    input wire logic cmp_ready_out,
    input wire logic chan_valid_out,
    input wire logic [7:0] chan_code_out,
    input wire logic chan_ready_in
);
    // Codes taken but not yet handed to the channel, pipeline included
    logic [7:0] occ_reg;
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            occ_reg <= 8'h00;
        else
            occ_reg <= occ_reg + 8'(cmp_valid_in && cmp_ready_out)
                - 8'(chan_valid_out && chan_ready_in);
    end
    default clocking dc @(posedge clock_in);
    endclocking
    default disable iff (srst_in);
    a_exp_latency: assert property (exp_valid_in |-> ##2 exp_valid_out)
        else $error("expander result missing");
    a_exp_cause: assert property (exp_valid_out |-> $past(exp_valid_in, 2))
        else $error("expander result without input");
    a_exp_value: assert property (exp_valid_out |->
        exp_sample_out == lcc_tb_pkg::mu_exp($past(exp_code_in, 2)))
        else $error("expander value wrong");
    a_chan_hold: assert property (chan_valid_out && !chan_ready_in |=>
        chan_valid_out && $stable(chan_code_out))
        else $error("channel code dropped while stalled");
    a_ready_start: assert property ($fell(srst_in) |->
        !cmp_ready_out ##[1:2] cmp_ready_out)
        else $error("compressor ready wrong after reset");
    a_chan_backed: assert property (chan_valid_out |-> occ_reg != 8'h00)
        else $error("channel code without sample");
    a_cmp_latency: assert property (cmp_valid_in && cmp_ready_out &&
        occ_reg == 8'h00 |-> ##4 chan_valid_out)
        else $error("compressor latency wrong");
    a_occ_bound: assert property (occ_reg <= 8'(FIFO_DEPTH + 1))
        else $error("buffer overfilled");
endmodule : lcc_top_checker
bind lcc_top lcc_top_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.clock_in, .srst_in,
    .exp_valid_in, .exp_code_in, .exp_valid_out, .exp_sample_out, .cmp_valid_in,
    .cmp_ready_out, .chan_valid_out, .chan_code_out, .chan_ready_in);

// *** testbench/test_log_companding_codec.sv ***
// Self-checking bench for the companding codec.
// Assumes lcc_params.svh on the include path and the channel sink model.
`timescale 1ns/1ns
`include "lcc_params.svh"
module test_log_companding_codec;
    logic clock_in, srst_in, exp_valid_in, cmp_valid_in, hold, slow;
    logic exp_valid_out, cmp_ready_out, chan_valid_out, chan_ready_in;
    logic [7:0] exp_code_in, chan_code_out;
    logic signed [13:0] exp_sample_out;
    logic signed [12:0] cmp_sample_in;
    int error_cnt = 0;
    int n_tests = 0;
    lcc_top dut_u (.clock_in, .srst_in, .exp_valid_in, .exp_code_in, .exp_valid_out,
        .exp_sample_out, .cmp_valid_in, .cmp_sample_in, .cmp_ready_out, .chan_valid_out,
        .chan_code_out, .chan_ready_in);
    lcc_chan_model chan_u (.clock_in, .hold_in(hold), .slow_in(slow),
        .chan_valid_in(chan_valid_out), .chan_code_in(chan_code_out),
        .chan_ready_out(chan_ready_in));
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : check
    task automatic report_and_stop;
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // Every code back to back, so any latency slip shows on all of them
    task automatic exp_all;
        for (int j = 0; j < 258; j++)
        begin
            @(posedge clock_in);
            exp_valid_in <= j < 256;
            exp_code_in <= 8'(j);
            #1;
            if (j >= 2)
            begin
                check(exp_valid_out, 1'b1);
                check(exp_sample_out, lcc_tb_pkg::mu_exp(8'(j - 2)));
            end
        end
        @(posedge clock_in);
        #1;
        check(exp_valid_out, 1'b0);
    endtask : exp_all
    // Fill against a stalled channel until refused, then drain slowly
    task automatic cmp_stream;
        logic [12:0] sp[8] = '{13'h1000, 13'h0000, 13'h1fff, 13'h001f,
            13'h0020, 13'h0fff, 13'h1fdf, 13'h0021};
        logic signed [12:0] smp[40];
        int k = 0;
        int refused = 0;
        logic rdy = 1'b0;
        for (int i = 0; i < 40; i++)
            smp[i] = (i < 8) ? sp[i] : 13'(i * 205 - 4096);
        for (int t = 0; t < 2000 && k < 40; t++)
        begin
            @(posedge clock_in);
            if (cmp_valid_in && rdy)
                k++;
            if (!rdy && k > 0)
                refused++;
            hold <= refused < 4;
            slow <= 1'b1;
            cmp_valid_in <= k < 40;
            cmp_sample_in <= smp[k % 40];
            #1;
            rdy = cmp_ready_out;
        end
        check(k, 40);
        check(refused > 0, 1'b1);
        for (int t = 0; t < 500 && chan_u.got_q.size() < 40; t++)
            @(posedge clock_in);
        check(chan_u.got_q.size(), 40);
        for (int i = 0; i < chan_u.got_q.size(); i++)
            check(chan_u.got_q[i], lcc_tb_pkg::a_cmp(smp[i]));
        #1;
        check(chan_valid_out, 1'b0);
    endtask : cmp_stream
    initial
    begin
        srst_in = 1'b1;
        exp_valid_in = 1'b0;
        exp_code_in = 8'h00;
        cmp_valid_in = 1'b0;
        cmp_sample_in = 13'h0000;
        hold = 1'b0;
        slow = 1'b0;
        repeat (4) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        check(cmp_ready_out, 1'b0);
        exp_all();
        cmp_stream();
        report_and_stop();
    end
endmodule : test_log_companding_codec
